// ===== rtl/ras_pkg.sv
// Constants and types shared by the return address stack files
package ras_pkg;

    // ****************************************************************
    // Widths and depth
    // ****************************************************************
    localparam int PTR_W   = 5;
    localparam int PC_W    = 21;
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 8;
    localparam int DEPTH   = 31;
    localparam int UPPER_W = 5;

    // ****************************************************************
    // Pointer values
    // ****************************************************************
    localparam logic [PTR_W-1:0] PTR_ZERO = 5'h00;
    localparam logic [PTR_W-1:0] PTR_ONE  = 5'h01;
    localparam logic [PTR_W-1:0] PTR_MAX  = 5'h1F;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_PTR       = 12'hFFC;
    localparam logic [ADDR_W-1:0] ADDR_TOS_LOW   = 12'hFFD;
    localparam logic [ADDR_W-1:0] ADDR_TOS_HIGH  = 12'hFFE;
    localparam logic [ADDR_W-1:0] ADDR_TOS_UPPER = 12'hFFF;

    // ****************************************************************
    // Field positions and values
    // ****************************************************************
    localparam int FULL_BIT  = 7;
    localparam int UNF_BIT   = 6;
    localparam int PTR_HI    = 4;
    localparam int LOW_LSB   = 0;
    localparam int HIGH_LSB  = 8;
    localparam int UPPER_LSB = 16;

    localparam logic [PC_W-1:0]   PC_STEP    = 21'h000002;
    localparam logic [PC_W-1:0]   PC_ZERO    = 21'h000000;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
    localparam logic [2:0]        UPPER_PAD  = 3'h0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum {
        OP_IDLE,
        OP_PUSH,
        OP_POP,
        OP_DISCARD
    } ras_op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } ras_reg_req_s;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] work;
        logic [3:0] bank;
    } ras_shadow_s;

endpackage

// ===== rtl/ras_stack_mem.sv
// Return address storage, entries one to thirty-one
`timescale 1ns/1ps
module ras_stack_mem
(
    // Clock
    input  wire logic                         core_clk,
    // Write port
    input  wire logic                         wr_en,
    input  wire logic [ras_pkg::PTR_W-1:0]    wr_idx,
    input  wire logic [ras_pkg::PC_W-1:0]     wr_data,
    // Read port
    input  wire logic [ras_pkg::PTR_W-1:0]    rd_idx,
    output logic      [ras_pkg::PC_W-1:0]     rd_data
);
    import ras_pkg::*;

    logic [PC_W-1:0] entry_reg [1:DEPTH];

    // ****************************************************************
    // Storage
    // ****************************************************************
    genvar g;
    generate
        for (g = 1; g <= DEPTH; g = g + 1)
        begin : gen_entry
            always_ff @(posedge core_clk)
            begin
                if (wr_en && wr_idx == PTR_W'(g))
                    entry_reg[g] <= wr_data;
            end
        end
    endgenerate

    // Index zero has no storage and reads zero
    assign rd_data = (rd_idx == PTR_ZERO) ? PC_ZERO : entry_reg[rd_idx];

endmodule

// ===== rtl/ras_shadow.sv
// One-level shadow of status, working and bank select registers
`timescale 1ns/1ps
module ras_shadow
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // Save and restore strobes
    input  wire logic                 save,
    input  wire logic                 restore,
    // Register values
    input  wire ras_pkg::ras_shadow_s live_regs,
    output ras_pkg::ras_shadow_s      restore_regs,
    output logic                      restore_valid
);
    import ras_pkg::*;

    ras_shadow_s shadow_reg;
    ras_shadow_s out_reg;
    logic        valid_reg;

    // ****************************************************************
    // Shadow copy
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (srst)
            shadow_reg <= '0;
        else if (save)
            shadow_reg <= live_regs;                        // [R16] [R18] [R19]
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            out_reg   <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= restore;                           // [R17] [R18]
            if (restore)
                out_reg <= shadow_reg;                      // [R17] [R18]
        end
    end

    assign restore_regs  = out_reg;
    assign restore_valid = valid_reg;

endmodule

// ===== rtl/ras_top.sv
// Return address stack with pointer, flags, top access and shadow
//
// Behaviour
// [R1] Five-bit pointer, values zero through 31
// [R2] Push increments then stores; pop reads then decrements
// [R3] Every reset clears the pointer
// [R4] Software reads and writes the pointer
// [R5] Full flag set on 31st unpopped push
// [R6] Flags kept until software clear or power-on
// [R7] Reset enabled: 31st push stores pc+2, resets
// [R8] Reset disabled: pointer stops at 31, no overwrite
// [R9] Pop at zero returns zero, sets underflow
// [R10] Full or underflow requests reset only when enabled
// [R11] Underflow without reset leaves registers untouched
// [R12] Software push increments and stores current pc
// [R13] Software pop only decrements the pointer
// [R14] Software writes top entry byte registers
// [R15] Pointer register: full, underflow, zero, pointer
// [R16] Shadow loaded on every interrupt vector
// [R17] Fast interrupt return restores shadow values
// [R18] Fast call saves, fast return restores
// [R19] Nested interrupt overwrites earlier shadow copy
// [R20] Storage is 31 words of 21 bits
// [R21] Calls and interrupts push; returns pop
// [R22] Top byte registers show addressed entry
// [R23] Writing zero clears a flag; one keeps
`timescale 1ns/1ps
module ras_top
(
    // Clock and resets
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    input  wire logic                          dev_reset,
    // Configuration
    input  wire logic                          overflow_reset_enable,
    // Core push and pop
    input  wire logic                          push_req,
    input  wire logic                          pop_req,
    input  wire logic                          discard_req,
    input  wire logic [ras_pkg::PC_W-1:0]      push_pc,
    output logic                               pop_valid,
    output logic      [ras_pkg::PC_W-1:0]      pop_pc,
    // Shadow stack control
    input  wire logic                          irq_vector,
    input  wire logic                          fast_call,
    input  wire logic                          fast_return,
    input  wire ras_pkg::ras_shadow_s          live_regs,
    output logic                               restore_valid,
    output ras_pkg::ras_shadow_s               restore_regs,
    // Register port
    input  wire ras_pkg::ras_reg_req_s         reg_req,
    output logic      [ras_pkg::DATA_W-1:0]    reg_rdata,
    // Status
    output logic                               stack_full_flag,
    output logic                               stack_underflow_flag,
    output logic      [ras_pkg::PTR_W-1:0]     pointer_value,
    output logic                               device_reset_req
);
    import ras_pkg::*;

    // ****************
    // Functions
    // ****************
    function automatic logic reg_hit
    (
        input ras_reg_req_s      req,
        input logic [ADDR_W-1:0] target
    );
        reg_hit = (req.addr == target);
    endfunction

    function automatic logic [PC_W-1:0] tos_merge
    (
        input logic [PC_W-1:0]   entry,
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] data
    );
        logic [PC_W-1:0] merged;
        merged = entry;
        if (addr == ADDR_TOS_LOW)
            merged[LOW_LSB +: DATA_W] = data;
        else if (addr == ADDR_TOS_HIGH)
            merged[HIGH_LSB +: DATA_W] = data;
        else if (addr == ADDR_TOS_UPPER)
            merged[UPPER_LSB +: UPPER_W] = data[UPPER_W-1:0];
        tos_merge = merged;
    endfunction

    // ****************
    // State
    // ****************
    logic [PTR_W-1:0]  ptr_reg;
    logic [PTR_W-1:0]  ptr_next;
    logic              full_reg;
    logic              full_next;
    logic              unf_reg;
    logic              unf_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [PC_W-1:0]   pop_pc_reg;
    logic [PC_W-1:0]   pop_pc_next;
    logic              pop_valid_reg;
    logic              rst_req_reg;
    logic              rst_req_next;

    // ****************
    // Operation select
    // ****************
    ras_op_e op_sel;

    assign op_sel = push_req    ? OP_PUSH    :          // [R21] [R12]
                    pop_req     ? OP_POP     :          // [R21]
                    discard_req ? OP_DISCARD :          // [R13]
                                  OP_IDLE;

    logic is_push;
    logic is_pop;
    logic is_discard;
    logic is_idle;

    assign is_push    = (op_sel == OP_PUSH);
    assign is_pop     = (op_sel == OP_POP);
    assign is_discard = (op_sel == OP_DISCARD);
    assign is_idle    = (op_sel == OP_IDLE);

    // ****************
    // Pointer arithmetic
    // ****************
    logic             at_zero;
    logic             at_top;
    logic [PTR_W-1:0] ptr_inc;
    logic [PTR_W-1:0] ptr_dec;

    assign at_zero = (ptr_reg == PTR_ZERO);
    assign at_top  = (ptr_reg == PTR_MAX);                  // [R1]
    assign ptr_inc = ptr_reg + PTR_ONE;                     // [R2]
    assign ptr_dec = ptr_reg - PTR_ONE;                     // [R2]

    // ****************
    // Register decode
    // ****************
    logic ptr_wr;
    logic tos_sel;
    logic tos_wr;

    assign ptr_wr  = reg_req.we && reg_hit(reg_req, ADDR_PTR);
    assign tos_sel = reg_hit(reg_req, ADDR_TOS_LOW)
                  || reg_hit(reg_req, ADDR_TOS_HIGH)
                  || reg_hit(reg_req, ADDR_TOS_UPPER);
    assign tos_wr  = reg_req.we && tos_sel;

    // ****************
    // Push and pop conditions
    // ****************
    logic            push_fills;
    logic            push_store;
    logic            pull;
    logic            full_set;
    logic            unf_set;
    logic [PC_W-1:0] push_data;

    assign push_fills = is_push && (ptr_inc == PTR_MAX);    // [R5]
    assign push_store = is_push && !at_top;                 // [R8]
    assign pull       = is_pop || is_discard;
    assign full_set   = push_fills || (is_push && at_top);  // [R5]
    assign unf_set    = pull && at_zero;                    // [R9]

    assign push_data  = (push_fills && overflow_reset_enable)
                      ? push_pc + PC_STEP                   // [R7]
                      : push_pc;                            // [R12]

    // ****************
    // Stack storage
    // ****************
    logic             mem_wr_en;
    logic [PTR_W-1:0] mem_wr_idx;
    logic [PC_W-1:0]  mem_wr_data;
    logic [PC_W-1:0]  top_entry;

    assign mem_wr_en   = push_store
                      || (tos_wr && is_idle && !at_zero);   // [R14]
    assign mem_wr_idx  = push_store ? ptr_inc : ptr_reg;    // [R2]
    assign mem_wr_data = push_store
                       ? push_data
                       : tos_merge(top_entry, reg_req.addr,
                                   reg_req.wdata);          // [R14]

    ras_stack_mem u_mem
    (
        .core_clk (core_clk),
        .wr_en    (mem_wr_en),
        .wr_idx   (mem_wr_idx),
        .wr_data  (mem_wr_data),
        .rd_idx   (ptr_reg),
        .rd_data  (top_entry)                               // [R20] [R22]
    );

    // ****************
    // Next pointer
    // ****************
    logic [PTR_W-1:0] ptr_push;
    logic [PTR_W-1:0] ptr_pull;
    logic [PTR_W-1:0] ptr_idle;

    assign ptr_push = at_top ? ptr_reg : ptr_inc;           // [R8]
    assign ptr_pull = at_zero ? ptr_reg : ptr_dec;          // [R9] [R13]
    assign ptr_idle = ptr_wr
                    ? reg_req.wdata[PTR_HI:0]               // [R4]
                    : ptr_reg;

    assign ptr_next = dev_reset ? PTR_ZERO :                // [R3] [R7]
                      is_push   ? ptr_push :
                      pull      ? ptr_pull :
                                  ptr_idle;

    // ****************
    // Flags
    // ****************
    logic full_keep;
    logic unf_keep;

    assign full_keep = !(ptr_wr && !reg_req.wdata[FULL_BIT]);  // [R23]
    assign unf_keep  = !(ptr_wr && !reg_req.wdata[UNF_BIT]);   // [R23]

    assign full_next = full_set || (full_reg && full_keep);    // [R6]
    assign unf_next  = unf_set  || (unf_reg  && unf_keep);     // [R6]

    // ****************
    // Device reset request
    // ****************
    assign rst_req_next = overflow_reset_enable
                       && (full_set || unf_set);            // [R10] [R7]

    // ****************
    // Pop result
    // ****************
    assign pop_pc_next = at_zero ? PC_ZERO : top_entry;     // [R9] [R11]

    // ****************
    // Read data
    // ****************
    logic [DATA_W-1:0] ptr_view;
    logic [DATA_W-1:0] read_sel;

    assign ptr_view = {full_reg, unf_reg, 1'b0, ptr_reg};   // [R15]

    assign read_sel =
        reg_hit(reg_req, ADDR_PTR)       ? ptr_view :       // [R4] [R15]
        reg_hit(reg_req, ADDR_TOS_LOW)   ?
            top_entry[LOW_LSB +: DATA_W] :                  // [R22]
        reg_hit(reg_req, ADDR_TOS_HIGH)  ?
            top_entry[HIGH_LSB +: DATA_W] :                 // [R22]
        reg_hit(reg_req, ADDR_TOS_UPPER) ?
            {UPPER_PAD, top_entry[UPPER_LSB +: UPPER_W]} :  // [R22]
            DATA_ZERO;

    assign rdata_next = reg_req.re ? read_sel : DATA_ZERO;

    // ****************
    // Pointer and flag registers
    // ****************
    always_ff @(posedge core_clk)
    begin
        if (srst)
            ptr_reg <= PTR_ZERO;                            // [R3]
        else
            ptr_reg <= ptr_next;                            // [R1] [R2]
    end

    // Flags survive the device reset; power-on or a software zero write clears them
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            full_reg <= 1'b0;                               // [R6]
            unf_reg  <= 1'b0;                               // [R6]
        end
        else
        begin
            full_reg <= full_next;                          // [R5]
            unf_reg  <= unf_next;                           // [R9]
        end
    end

    // ****************
    // Output registers
    // ****************
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pop_valid_reg <= 1'b0;
            pop_pc_reg    <= PC_ZERO;
        end
        else
        begin
            pop_valid_reg <= is_pop;                        // [R21]
            pop_pc_reg    <= is_pop ? pop_pc_next : pop_pc_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rst_req_reg <= 1'b0;
            rdata_reg   <= DATA_ZERO;
        end
        else
        begin
            rst_req_reg <= rst_req_next;                    // [R10]
            rdata_reg   <= rdata_next;
        end
    end

    // ****************
    // Shadow stack
    // ****************
    logic shadow_save;

    assign shadow_save = irq_vector || fast_call;           // [R16] [R18]

    ras_shadow u_shadow
    (
        .core_clk      (core_clk),
        .srst          (srst),
        .save          (shadow_save),                       // [R19]
        .restore       (fast_return),                       // [R17]
        .live_regs     (live_regs),
        .restore_regs  (restore_regs),
        .restore_valid (restore_valid)
    );

    // ****************
    // Outputs
    // ****************
    assign pop_valid            = pop_valid_reg;
    assign pop_pc               = pop_pc_reg;
    assign device_reset_req     = rst_req_reg;
    assign reg_rdata            = rdata_reg;
    assign stack_full_flag      = full_reg;
    assign stack_underflow_flag = unf_reg;
    assign pointer_value        = ptr_reg;

endmodule

// ===== verification/ras_monitor.sv
// Port checks for the return address stack
`timescale 1ns/1ps
module ras_monitor
(
    // Clock, resets, config
    input wire logic                       core_clk,
    input wire logic                       srst,
    input wire logic                       dev_reset,
    input wire logic                       overflow_reset_enable,
    // Core side
    input wire logic                       push_req,
    input wire logic                       pop_req,
    input wire logic                       pop_valid,
    input wire logic [ras_pkg::PC_W-1:0]   pop_pc,
    input wire logic                       irq_vector,
    input wire logic                       fast_call,
    input wire logic                       fast_return,
    input wire ras_pkg::ras_shadow_s       live_regs,
    input wire ras_pkg::ras_shadow_s       restore_regs,
    // Registers and status
    input wire ras_pkg::ras_reg_req_s      reg_req,
    input wire logic [ras_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                       stack_full_flag,
    input wire logic                       stack_underflow_flag,
    input wire logic [ras_pkg::PTR_W-1:0]  pointer_value,
    input wire logic                       device_reset_req
);
    import ras_pkg::*;
    default clocking mon_cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ****************
    // Assertions
    // ****************
    chk_push_step: assert property (
        push_req && pointer_value < PTR_MAX && !dev_reset
        |=> pointer_value == $past(pointer_value) + PTR_ONE)
        else $error("push did not advance pointer");
    chk_pop_step: assert property (
        pop_req && !push_req && pointer_value != PTR_ZERO && !dev_reset
        |=> pop_valid && pointer_value == $past(pointer_value) - PTR_ONE)
        else $error("pop did not retreat pointer");
    chk_pop_under: assert property (
        pop_req && !push_req && pointer_value == PTR_ZERO
        |=> pop_pc == PC_ZERO && stack_underflow_flag
            && pointer_value == PTR_ZERO)
        else $error("underflow pop wrong");
    chk_full_set: assert property (
        push_req && pointer_value == 5'h1E |=> stack_full_flag)
        else $error("full flag not set");
    chk_full_stop: assert property (
        push_req && pointer_value == PTR_MAX && !dev_reset
        |=> pointer_value == PTR_MAX && stack_full_flag)
        else $error("pointer moved past top");
    chk_reset_req: assert property (
        push_req && pointer_value == 5'h1E && overflow_reset_enable
        |=> device_reset_req)
        else $error("overflow reset not requested");
    chk_req_enabled: assert property (
        device_reset_req |-> $past(overflow_reset_enable))
        else $error("reset request while disabled");
    chk_flag_clear: assert property (
        $fell(stack_full_flag) |-> $past(srst) || $past(reg_req.we
        && reg_req.addr == ADDR_PTR && !reg_req.wdata[FULL_BIT]))
        else $error("full flag cleared without cause");
    chk_ptr_read: assert property (
        reg_req.re && reg_req.addr == ADDR_PTR |=> reg_rdata ==
        {$past(stack_full_flag), $past(stack_underflow_flag), 1'b0,
         $past(pointer_value)})
        else $error("pointer register read wrong");
    chk_shadow_trip: assert property (
        irq_vector && !fast_return ##1 fast_return && !irq_vector
        && !fast_call |=> restore_regs == $past(live_regs, 2))
        else $error("shadow restore wrong");
endmodule

// ===== verification/ras_core_model.sv
// Instruction sequencer stand-in: pushes, pops, shadow strobes
`timescale 1ns/1ps
module ras_core_model
(
    // Clock
    input wire logic                     core_clk,
    // Stack requests
    output logic                         push_req,
    output logic                         pop_req,
    output logic                         discard_req,
    output logic [ras_pkg::PC_W-1:0]     push_pc,
    // Shadow strobes
    output logic                         irq_vector,
    output logic                         fast_call,
    output logic                         fast_return,
    output ras_pkg::ras_shadow_s         live_regs
);
    import ras_pkg::*;

    initial
    begin
        {push_req, pop_req, discard_req, push_pc} = '0;
        {irq_vector, fast_call, fast_return, live_regs} = '0;
    end

    // One request per edge; idle address lines toggle
    task automatic op(input ras_op_e k, input logic [PC_W-1:0] pc);
        @(posedge core_clk);
        push_req    <= (k == OP_PUSH);
        pop_req     <= (k == OP_POP);
        discard_req <= (k == OP_DISCARD);
        push_pc     <= (k == OP_PUSH) ? pc : ~push_pc;
    endtask

    // Strobes given as {irq, call, return}
    task automatic sh(input logic [2:0] k, input ras_shadow_s r);
        @(posedge core_clk);
        {irq_vector, fast_call, fast_return} <= k;
        live_regs <= r;
    endtask
endmodule

// ===== verification/ras_top_test.sv
// Self-checking bench for the return address stack
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("FAIL t=%0t got %h exp %h", $time, g, e); \
        end \
    end
module ras_top_test;
    import ras_pkg::*;
    logic core_clk = 1'b0;
    logic srst, dev_reset, overflow_reset_enable;
    logic push_req, pop_req, discard_req, irq_vector;
    logic fast_call, fast_return, pop_valid, restore_valid;
    logic [PC_W-1:0] push_pc, pop_pc;
    ras_shadow_s live_regs, restore_regs;
    ras_reg_req_s reg_req;
    logic [DATA_W-1:0] reg_rdata;
    logic stack_full_flag, stack_underflow_flag, device_reset_req;
    logic [PTR_W-1:0] pointer_value;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;

    always #4 core_clk = ~core_clk;

    ras_top i_ras_top (.core_clk, .srst, .dev_reset,
        .overflow_reset_enable, .push_req, .pop_req, .discard_req,
        .push_pc, .pop_valid, .pop_pc, .irq_vector, .fast_call,
        .fast_return, .live_regs, .restore_valid, .restore_regs,
        .reg_req, .reg_rdata, .stack_full_flag, .stack_underflow_flag,
        .pointer_value, .device_reset_req);
    ras_core_model u_core (.core_clk, .push_req, .pop_req,
        .discard_req, .push_pc, .irq_vector, .fast_call, .fast_return,
        .live_regs);

    // ****************
    // Bus and helper tasks
    // ****************
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= {a, d, 2'b10};
        @(posedge core_clk);
        reg_req <= {~a, ~d, 2'b00};
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_req <= {a, 8'h00, 2'b01};
        @(posedge core_clk);
        reg_req <= {~a, 8'hFF, 2'b00};
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic go(input ras_op_e k, input logic [PC_W-1:0] pc);
        u_core.op(k, pc);
        u_core.op(OP_IDLE, PC_ZERO);
        #1;
    endtask
    task automatic pulse(input logic por);
        @(posedge core_clk);
        if (por)
            srst <= 1'b1;
        else
            dev_reset <= 1'b1;
        @(posedge core_clk);
        {srst, dev_reset} <= 2'b00;
        #1;
    endtask
    task automatic cfg(input logic en);
        @(posedge core_clk);
        overflow_reset_enable <= en;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_push_pop();
        rdc(ADDR_PTR, 8'h00);
        rdc(12'h123, 8'h00);
        go(OP_PUSH, 21'h1ABCD4);
        `CHK(pointer_value, 5'h01)
        rdc(ADDR_TOS_LOW, 8'hD4);
        rdc(ADDR_TOS_HIGH, 8'hBC);
        rdc(ADDR_TOS_UPPER, 8'h1A);
        go(OP_POP, PC_ZERO);
        `CHK({pop_valid, pop_pc}, {1'b1, 21'h1ABCD4})
        `CHK(pointer_value, 5'h00)
    endtask
    task automatic t_underflow();
        cfg(1'b1);
        go(OP_POP, PC_ZERO);
        `CHK({pop_pc, stack_underflow_flag}, {PC_ZERO, 1'b1})
        `CHK(device_reset_req, 1'b1)
        pulse(1'b0);
        rdc(ADDR_PTR, 8'h40);
        wr(ADDR_PTR, 8'hC0);
        rdc(ADDR_PTR, 8'h40);
        wr(ADDR_PTR, 8'h00);
        rdc(ADDR_PTR, 8'h00);
        cfg(1'b0);
        go(OP_DISCARD, PC_ZERO);
        `CHK({stack_underflow_flag, device_reset_req}, 2'b10)
        wr(ADDR_PTR, 8'h00);
    endtask
    task automatic t_fill();
        for (int i = 1; i <= DEPTH; i++)
            u_core.op(OP_PUSH, PC_W'(i * 2));
        go(OP_IDLE, PC_ZERO);
        `CHK({stack_full_flag, pointer_value}, {1'b1, PTR_MAX})
        go(OP_PUSH, 21'h0000AA);
        `CHK(pointer_value, PTR_MAX)
        rdc(ADDR_TOS_LOW, 8'h3E);
        go(OP_DISCARD, PC_ZERO);
        `CHK(pointer_value, 5'h1E)
        rdc(ADDR_TOS_LOW, 8'h3C);
        wr(ADDR_PTR, 8'h00);
        rdc(ADDR_PTR, 8'h00);
    endtask
    task automatic t_overflow();
        cfg(1'b1);
        wr(ADDR_PTR, 8'h1E);
        rdc(ADDR_PTR, 8'h1E);
        go(OP_PUSH, 21'h000100);
        `CHK({device_reset_req, stack_full_flag}, 2'b11)
        rdc(ADDR_TOS_LOW, 8'h02);
        rdc(ADDR_TOS_HIGH, 8'h01);
        pulse(1'b0);
        `CHK({stack_full_flag, pointer_value}, 6'h20)
        pulse(1'b1);
        `CHK(stack_full_flag, 1'b0)
    endtask
    task automatic t_sw_write();
        cfg(1'b0);
        wr(ADDR_PTR, 8'h03);
        wr(ADDR_TOS_LOW, 8'h56);
        wr(ADDR_TOS_HIGH, 8'h34);
        wr(ADDR_TOS_UPPER, 8'h12);
        rdc(ADDR_TOS_UPPER, 8'h12);
        go(OP_POP, PC_ZERO);
        `CHK({pop_pc, pointer_value}, {21'h123456, 5'h02})
    endtask
    task automatic t_shadow();
        u_core.sh(3'b100, ras_shadow_s'(20'hA1B2C));
        u_core.sh(3'b100, ras_shadow_s'(20'h3D4E5));
        u_core.sh(3'b001, ras_shadow_s'(20'hFFFFF));
        u_core.sh(3'b000, ras_shadow_s'(20'h00000));
        #1;
        `CHK({restore_valid, restore_regs}, {1'b1, 20'h3D4E5})
        u_core.sh(3'b010, ras_shadow_s'(20'h96A5B));
        u_core.sh(3'b001, ras_shadow_s'(20'h12345));
        u_core.sh(3'b000, ras_shadow_s'(20'h00000));
        #1;
        `CHK({restore_valid, restore_regs}, {1'b1, 20'h96A5B})
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            test_done();
        end
    end

    initial
    begin
        srst = 1'b1;
        dev_reset = 1'b0;
        overflow_reset_enable = 1'b0;
        reg_req = '0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        t_push_pop();
        t_underflow();
        t_fill();
        t_overflow();
        t_sw_write();
        t_shadow();
        test_done();
    end
endmodule

bind ras_top ras_monitor i_ras_monitor (.core_clk, .srst, .dev_reset,
    .overflow_reset_enable, .push_req, .pop_req, .pop_valid, .pop_pc,
    .irq_vector, .fast_call, .fast_return, .live_regs, .restore_regs,
    .reg_req, .reg_rdata, .stack_full_flag, .stack_underflow_flag,
    .pointer_value, .device_reset_req);
